// ### design/sciw_consts.svh
`ifndef SCIW_CONSTS_SVH
`define SCIW_CONSTS_SVH

// register indices; byte address is four times the index
`define SCIW_IDX_BDH 10'h070
`define SCIW_IDX_BDL 10'h071
`define SCIW_IDX_C1 10'h072
`define SCIW_IDX_C2 10'h073
`define SCIW_IDX_ST 10'h074
`define SCIW_IDX_DH 10'h076
`define SCIW_IDX_DL 10'h077

// reset values
`define SCIW_RST_BDH 8'h00
`define SCIW_RST_BDL 8'h04
`define SCIW_RST_C1 8'h00

// baud high layout
`define SCIW_BDH_TEST 7
`define SCIW_BDH_SPLIT 6
`define SCIW_BDH_DIV_HI 4

// control two layout
`define SCIW_C2_TXEN 3
`define SCIW_C2_RXEN 2
`define SCIW_C2_SLEEP 1
`define SCIW_C2_BREAK 0

// data upper layout
`define SCIW_DH_RX8 7
`define SCIW_DH_TX8 6

// oversampling: sixteen phases, votes on the middle three
`define SCIW_PH_LAST 4'hf
`define SCIW_PH_V0 4'h7
`define SCIW_PH_V1 4'h8
`define SCIW_PH_V2 4'h9
`define SCIW_DIV_ZERO 13'h0000
`define SCIW_DIV_ONE 13'h0001

// last data bit index for 8 and 9 bit frames
`define SCIW_LAST8 4'h7
`define SCIW_LAST9 4'h8

// idle threshold in samples: whole frame of ones
`define SCIW_IDLE8 8'ha0
`define SCIW_IDLE9 8'hb0

`endif

// ### design/sciw_pkg.sv
package sciw_pkg;

	// control one fields, msb first
	typedef struct packed {
		logic internal_loopback;
		logic open_drain_pins;
		logic rsv;
		logic word9;
		logic wakeAddr;
		logic idle_count_type;
		logic parity_enable;
		logic parity_odd_select;
	} sciw_ctrl1_s;

	// status one fields, msb first
	typedef struct packed {
		logic txEmpty;
		logic txDone;
		logic rx_full_flag;
		logic idle;
		logic overrun;
		logic noise_flag;
		logic framing_error_flag;
		logic parity_error_flag;
	} sciw_stat_s;

	typedef enum logic [3:0] {
		TX_IDLE = 4'b0001,
		TX_START = 4'b0010,
		TX_DATA = 4'b0100,
		TX_STOP = 4'b1000
	} sciw_tx_e;

	typedef enum logic [3:0] {
		RX_IDLE = 4'b0001,
		RX_START = 4'b0010,
		RX_DATA = 4'b0100,
		RX_STOP = 4'b1000
	} sciw_rx_e;

endpackage

// ### design/sciw_top.sv
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`include "sciw_consts.svh"

// How it works
// - wake select one: msb marks address frame
// - frame is info bits plus marking msb
// - address mark clears sleep before stop bit
// - full buffer: set overrun, drop new word
// - overrun clears on status then data read
// - noise on any bit, shown with full
// - missing stop sets framing with full flag
// - framing plus overrun reports overrun only
// - framing flag blocks transfers until cleared
// - parity error set, cleared by read pair
// - baud is clock over sixteen times divisor
// - divisor zero stops the baud generator
// - loopback feeds transmitter into receiver
// - loopback holds pin high when enabled
// - open drain select makes pin open drain
// - word select picks nine or eight bits
// - idle type chooses where ones counting starts
// - odd or even parity bit value
// - bit five of two registers reads zero
// - sleep inhibits all receive flags
// - idle wake mode clears sleep on idle
// - lsb first, zero start, one stop
module sciw_top
	import sciw_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxdIn,
	output logic txdOut,
	output logic txdOe
);
	////////////////////////////////////////////////////////////////////
	// helpers
	// xor of the data bits below the top bit of the frame
	function automatic logic parityOf(input logic [8:0] w, input logic w9);
		parityOf = w9 ? ^w[7:0] : ^w[6:0];
	endfunction
	// index of the last data bit for the chosen word length
	function automatic logic [3:0] lastBit(input logic w9);
		lastBit = w9 ? `SCIW_LAST9 : `SCIW_LAST8;
	endfunction
	////////////////////////////////////////////////////////////////////
	// registers and state
	logic [7:0] baudHigh; // test bits plus divisor top
	logic [7:0] baudLow; // divisor low byte
	sciw_ctrl1_s ctrl1; // line format and modes
	logic tx_enable, rx_enable, receiver_sleep, sendBreak; // control two bits
	sciw_stat_s flags; // sticky receive flags live here
	sciw_stat_s armed; // flags seen by the last status read
	logic [8:0] rxData; // word handed to software
	logic txHigh; // ninth transmit bit, waits for low write
	logic [12:0] baud_divisor, baudCnt; // divisor and tick counter
	logic tick; // one cycle per sixteenth of a bit
	sciw_tx_e txState;
	logic [3:0] txPhase, txIdx;
	logic [8:0] txShift, txBuf;
	logic txPending;
	logic txBit; // serial output before pin handling
	sciw_rx_e rxState;
	logic [3:0] rxPhase, rxIdx;
	logic [8:0] rxShift, evWord; // shifter and finished word
	logic [2:0] votes;
	logic noiseAcc; // any bit of this frame disagreed
	logic evFrame; // pulse: frame finished
	logic evStopOk, evNoise, evParErr; // status of the finished frame
	logic evAddr; // pulse: address mark seen
	logic [7:0] idleCnt;
	logic idleArmed;
	logic evIdle; // pulse: idle line found
	logic rxLine, bitVal, bitNoisy; // receive line and vote result
	logic [9:0] regIdx;
	logic access, wrHit, rdHit, mapped; // bus decode
	logic [7:0] readMux;
	logic txLevel, txDrive; // pin level and drive request
	////////////////////////////////////////////////////////////////////
	// apb decode
	assign regIdx = paddr[11:2];
	assign access = psel && penable;
	assign wrHit = access && pwrite;
	assign rdHit = access && !pwrite;
	assign pready = 1'b1; // never waits; read data is caught in setup
	assign mapped = regIdx inside {`SCIW_IDX_BDH, `SCIW_IDX_BDL, `SCIW_IDX_C1,
		`SCIW_IDX_C2, `SCIW_IDX_ST, `SCIW_IDX_DH, `SCIW_IDX_DL};
	assign pslverr = access && !mapped;

	// read value of the addressed register
	always_comb begin
		unique case (regIdx)
			`SCIW_IDX_BDH: readMux = {baudHigh[7:6], 1'b0, baudHigh[4:0]};
			`SCIW_IDX_BDL: readMux = baudLow;
			`SCIW_IDX_C1: readMux = {ctrl1[7:6], 1'b0, ctrl1[4:0]};
			`SCIW_IDX_C2: readMux = {4'h0, tx_enable, rx_enable, receiver_sleep, sendBreak};
			`SCIW_IDX_ST: readMux = flags;
			`SCIW_IDX_DH: readMux = {rxData[8], txHigh, 6'h00};
			`SCIW_IDX_DL: readMux = rxData[7:0];
			default: readMux = 8'h00;
		endcase
	end

	// read data registered in the setup cycle so it comes from a flop
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			prdata <= {24'h00_0000, readMux};
		end
	end
	////////////////////////////////////////////////////////////////////
	// control registers
	// baud and control one; test bits stored only
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			baudHigh <= `SCIW_RST_BDH;
			baudLow <= `SCIW_RST_BDL;
			ctrl1 <= `SCIW_RST_C1;
		end else if (wrHit) begin
			if (regIdx == `SCIW_IDX_BDH) begin
				baudHigh <= {pwdata[7:6], 1'b0, pwdata[4:0]};
			end
			if (regIdx == `SCIW_IDX_BDL) begin
				baudLow <= pwdata[7:0];
			end
			if (regIdx == `SCIW_IDX_C1) begin
				ctrl1 <= {pwdata[7:6], 1'b0, pwdata[4:0]};
			end
		end
	end

	// control two; hardware wakes the sleeper, a software write wins
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			tx_enable <= 1'b0;
			rx_enable <= 1'b0;
			receiver_sleep <= 1'b0;
			sendBreak <= 1'b0;
		end else begin
			if (evAddr && ctrl1.wakeAddr) begin
				receiver_sleep <= 1'b0;
			end
			if (evIdle && !ctrl1.wakeAddr) begin
				receiver_sleep <= 1'b0;
			end
			if (wrHit && regIdx == `SCIW_IDX_C2) begin
				tx_enable <= pwdata[`SCIW_C2_TXEN];
				rx_enable <= pwdata[`SCIW_C2_RXEN];
				receiver_sleep <= pwdata[`SCIW_C2_SLEEP];
				sendBreak <= pwdata[`SCIW_C2_BREAK];
			end
		end
	end
	////////////////////////////////////////////////////////////////////
	// baud generator
	assign baud_divisor = {baudHigh[`SCIW_BDH_DIV_HI:0], baudLow};

	// one tick every divisor clocks gives sixteen ticks per bit
	always_ff @(posedge ref_clk) begin
		if (sys_rst || baud_divisor == `SCIW_DIV_ZERO) begin
			baudCnt <= `SCIW_DIV_ZERO;
			tick <= 1'b0;
		end else if (baudCnt >= baud_divisor - `SCIW_DIV_ONE) begin
			baudCnt <= `SCIW_DIV_ZERO;
			tick <= 1'b1;
		end else begin
			baudCnt <= baudCnt + `SCIW_DIV_ONE;
			tick <= 1'b0;
		end
	end
	////////////////////////////////////////////////////////////////////
	// transmitter
	// buffer and shifter; a low data write queues the word
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			txState <= TX_IDLE;
			txPhase <= 4'h0;
			txIdx <= 4'h0;
			txShift <= 9'h000;
			txBuf <= 9'h000;
			txPending <= 1'b0;
			txHigh <= 1'b0;
		end else begin
			if (tick) begin
				txPhase <= txPhase + 4'h1;
				unique case (txState)
					TX_IDLE: begin
						txPhase <= 4'h0;
						if (txPending && tx_enable) begin
							txShift <= txBuf;
							if (ctrl1.parity_enable) begin // parity takes the top bit
								txShift[lastBit(ctrl1.word9)] <=
									parityOf(txBuf, ctrl1.word9) ^ ctrl1.parity_odd_select;
							end
							txPending <= 1'b0;
							txState <= TX_START;
						end
					end
					TX_START: begin
						if (txPhase == `SCIW_PH_LAST) begin
							txIdx <= 4'h0;
							txState <= TX_DATA;
						end
					end
					TX_DATA: begin
						if (txPhase == `SCIW_PH_LAST) begin
							txShift <= {1'b0, txShift[8:1]};
							txIdx <= txIdx + 4'h1;
							if (txIdx == lastBit(ctrl1.word9)) begin
								txState <= TX_STOP;
							end
						end
					end
					TX_STOP: begin
						if (txPhase == `SCIW_PH_LAST) begin
							txState <= TX_IDLE;
						end
					end
				endcase
			end
			if (wrHit && regIdx == `SCIW_IDX_DH) begin
				txHigh <= pwdata[`SCIW_DH_TX8];
			end
			if (wrHit && regIdx == `SCIW_IDX_DL) begin
				txBuf <= {txHigh, pwdata[7:0]}; // upper byte joins here
				txPending <= 1'b1;
			end
		end
	end

	// serial level: zero start, data lsb first, one stop
	always_comb begin
		unique case (txState)
			TX_START: txBit = 1'b0;
			TX_DATA: txBit = txShift[0];
			default: txBit = 1'b1;
		endcase
	end

	// pin driver; loopback parks the pin at idle high
	assign txLevel = ctrl1.internal_loopback ? 1'b1 : (txBit && !sendBreak);
	assign txDrive = tx_enable || txState != TX_IDLE;

	// pin outputs from flops; open drain only ever pulls low
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			txdOut <= 1'b1;
			txdOe <= 1'b0;
		end else if (ctrl1.open_drain_pins) begin
			txdOut <= 1'b0;
			txdOe <= txDrive && !txLevel;
		end else begin
			txdOut <= txLevel;
			txdOe <= txDrive;
		end
	end
	////////////////////////////////////////////////////////////////////
	// receiver
	assign rxLine = ctrl1.internal_loopback ? txBit : rxdIn;
	assign bitVal = (votes[0] & votes[1]) | (votes[0] & votes[2]) | (votes[1] & votes[2]);
	assign bitNoisy = !(&votes) && |votes;

	// frame sampler at sixteen per bit; misses a start when divisor is zero
	always_ff @(posedge ref_clk) begin
		if (sys_rst || !rx_enable) begin
			rxState <= RX_IDLE;
			rxPhase <= 4'h0;
			rxIdx <= 4'h0;
			rxShift <= 9'h000;
			votes <= 3'h7;
			noiseAcc <= 1'b0;
			evFrame <= 1'b0;
			evAddr <= 1'b0;
			evStopOk <= 1'b0;
			evNoise <= 1'b0;
			evParErr <= 1'b0;
			evWord <= 9'h000;
		end else begin
			evFrame <= 1'b0;
			evAddr <= 1'b0;
			if (tick) begin
				rxPhase <= rxPhase + 4'h1;
				if (rxPhase inside {`SCIW_PH_V0, `SCIW_PH_V1, `SCIW_PH_V2}) begin
					votes <= {votes[1:0], rxLine};
				end
				unique case (rxState)
					RX_IDLE: begin
						rxPhase <= 4'h0;
						if (!rxLine) begin
							noiseAcc <= 1'b0;
							rxState <= RX_START;
						end
					end
					RX_START: begin
						if (rxPhase == `SCIW_PH_LAST) begin
							rxIdx <= 4'h0;
							noiseAcc <= bitNoisy;
							rxState <= bitVal ? RX_IDLE : RX_DATA; // false start drops out
						end
					end
					RX_DATA: begin
						if (rxPhase == `SCIW_PH_LAST) begin
							rxShift <= {bitVal, rxShift[8:1]};
							noiseAcc <= noiseAcc | bitNoisy;
							rxIdx <= rxIdx + 4'h1;
							if (rxIdx == lastBit(ctrl1.word9)) begin
								evAddr <= bitVal; // msb set marks an address frame
								rxState <= RX_STOP;
							end
						end
					end
					RX_STOP: begin
						if (rxPhase == `SCIW_PH_LAST) begin
							evFrame <= 1'b1;
							evStopOk <= bitVal;
							evNoise <= noiseAcc | bitNoisy;
							evWord <= ctrl1.word9 ? rxShift : {1'b0, rxShift[8:1]};
							evParErr <= ctrl1.parity_enable &&
								((^rxShift) ^ ctrl1.word9 ^ ctrl1.word9 ^
								(ctrl1.word9 ? 1'b0 : rxShift[0])) != ctrl1.parity_odd_select;
							rxState <= RX_IDLE;
						end
					end
				endcase
			end
		end
	end

	// idle detector: a whole frame of ones; long type waits for a stop bit
	always_ff @(posedge ref_clk) begin
		if (sys_rst || !rx_enable) begin
			idleCnt <= 8'h00;
			idleArmed <= 1'b1;
			evIdle <= 1'b0;
		end else begin
			evIdle <= 1'b0;
			if (!rxLine) begin
				idleCnt <= 8'h00;
				idleArmed <= 1'b1; // line was active, next idle counts again
			end else if (tick && (!ctrl1.idle_count_type || rxState == RX_IDLE)) begin
				if (idleCnt != (ctrl1.word9 ? `SCIW_IDLE9 : `SCIW_IDLE8)) begin
					idleCnt <= idleCnt + 8'h01;
				end else if (idleArmed) begin
					evIdle <= 1'b1;
					idleArmed <= 1'b0;
				end
			end
		end
	end
	////////////////////////////////////////////////////////////////////
	// receive flags and data
	// status read arms a clear; the next data read clears what was seen
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			flags <= 8'h00;
			armed <= 8'h00;
			rxData <= 9'h000;
		end else begin
			flags.txEmpty <= !txPending;
			flags.txDone <= !txPending && txState == TX_IDLE;
			if (rdHit && regIdx == `SCIW_IDX_ST) begin
				armed <= flags;
			end
			if (rdHit && regIdx == `SCIW_IDX_DL) begin
				flags[5:0] <= flags[5:0] & ~armed[5:0];
				armed <= 8'h00;
			end
			// sets come after the clear so an event in the same cycle survives
			if (evIdle && !receiver_sleep) begin
				flags.idle <= 1'b1;
			end
			if (evFrame && !receiver_sleep) begin
				if (flags.rx_full_flag) begin
					flags.overrun <= 1'b1;
				end else if (!flags.framing_error_flag) begin
					rxData <= evWord;
					flags.rx_full_flag <= 1'b1;
					flags.framing_error_flag <= !evStopOk;
					flags.noise_flag <= evNoise;
					flags.parity_error_flag <= evParErr;
				end
			end
		end
	end
endmodule

// ### dv/sciw_top_asserts.sv
`timescale 1ns/1ps
module sciw_top_asserts
	import sciw_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic rxdIn,
	input wire logic txdOut,
	input wire logic txdOe
);
	logic [9:0] idx; // register index
	logic acc; // access phase
	logic lbNow; // loopback, transmitter on, push-pull pin
	sciw_ctrl1_s c1; // shadow of control one
	logic [3:0] c2; // shadow of control two; sleep bit may drift, unused
	logic [12:0] div; // shadow of the divisor
	assign idx = paddr[11:2];
	assign acc = psel && penable;
	assign lbNow = c1.internal_loopback && c2[3] && !c1.open_drain_pins;
	////////////////////////////////
	// shadows follow writes at the committing edge
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			c1 <= 8'h00;
			c2 <= 4'h0;
			div <= 13'h0004;
		end else if (acc && pwrite) begin
			case (idx)
				10'h070: div[12:8] <= pwdata[4:0];
				10'h071: div[7:0] <= pwdata[7:0];
				10'h072: c1 <= pwdata[7:0];
				10'h073: c2 <= pwdata[3:0];
				default: ;
			endcase
		end
	end
	////////////////////////////////
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	a_unmapped_err: assert property (acc |->
		pslverr == !(idx inside {[10'h070:10'h074], 10'h076, 10'h077}))
		else $error("error answer does not match map");
	a_bit5_zero: assert property (
		acc && !pwrite && idx inside {10'h070, 10'h072} |-> !prdata[5])
		else $error("bit five read as one");
	a_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h000000)
		else $error("upper read bits set");
	a_data_stands: assert property (acc |=> $stable(prdata))
		else $error("read data moved after access");
	a_reset_idle: assert property (disable iff (1'b0) sys_rst |=> txdOut && !txdOe)
		else $error("pin not idle after reset");
	a_open_drain: assert property (
		c1.open_drain_pins && $past(c1.open_drain_pins) |-> !txdOut)
		else $error("open drain pin driven high");
	a_loop_idle: assert property (lbNow && $past(lbNow) |-> txdOut && txdOe)
		else $error("pin not held high in loopback");
	a_div_stop: assert property (
		(div == 13'h0000 && $stable(c1) && $stable(c2)) [*3] |-> $stable(txdOut))
		else $error("pin moved with divisor zero");
	c_loop: cover property (lbNow);
	c_data: cover property (acc && !pwrite && idx == 10'h077);
	c_stop: cover property (acc && div == 13'h0000);
endmodule
bind sciw_top sciw_top_asserts u_chk (.*);

// ### dv/sciw_node.sv
`timescale 1ns/1ps
module sciw_node
	import sciw_pkg::*;
#(
	parameter int BIT = 16 // clocks per bit at divisor one
)
(
	input wire logic ref_clk,
	input wire logic txLine,
	output logic lineOut
);
	// the line rests at mark between frames
	initial lineOut = 1'b1;
	////////////////////////////////
	// one frame; m is {nine bits, bad stop, noisy start}
	task automatic send(input logic [8:0] d, input logic [2:0] m);
		logic [10:0] f;
		int s;
		f = m[2] ? {~m[1], d, 1'b0} : {1'b1, ~m[1], d[7:0], 1'b0};
		s = m[2] ? 10 : 9;
		for (int i = 0; i < 11; i++) begin
			for (int k = 0; k < BIT; k++) begin
				// one-sample glitch mid start; a bad stop rises late so no false start follows
				lineOut <= f[i] ^ (m[0] && i == 0 && k == BIT / 2) | (i == s && k >= 12);
				@(posedge ref_clk);
			end
		end
	endtask
	// decode one frame off the pin at mid bit
	task automatic recv(output logic [8:0] d, input logic nine);
		int n;
		d = 9'h000;
		n = 0;
		while (txLine !== 1'b0 && n < 400) begin
			@(posedge ref_clk);
			n++;
		end
		repeat (BIT / 2) @(posedge ref_clk);
		for (int i = 0; i < 9; i++) begin
			repeat (BIT) @(posedge ref_clk);
			if (i < 8 || nine) begin
				d[i] = txLine;
			end
		end
	endtask
endmodule

// ### dv/sciw_top_test.sv
`timescale 1ns/1ps
module sciw_top_test
	import sciw_pkg::*;
;
	logic ref_clk = 1'b0, sys_rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, rxdIn, txdOut, txdOe;
	logic txWire; // pin level, pulled up when released
	int failures = 0, compares = 0;
	assign txWire = txdOe ? txdOut : 1'b1;
	always #2.5 ref_clk = ~ref_clk;
	sciw_top dut (.*);
	sciw_node #(.BIT(16)) u_node (.ref_clk(ref_clk), .txLine(txWire), .lineOut(rxdIn));
	////////////////////////////////
	task automatic chk(input string n, input logic [31:0] g, input logic [31:0] x);
		compares++;
		if (g !== x) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic end_sim();
		if (failures == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// one transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d,
		output logic [31:0] r, output logic e);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			failures++;
			end_sim();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic wr(input logic [9:0] i, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, i, d, r, e);
	endtask
	task automatic rd(input logic [9:0] i, output logic [31:0] r);
		logic e;
		apb(1'b0, i, 8'h00, r, e);
	endtask
	// remote frame, then time for the flags to land
	task automatic fr(input logic [8:0] d, input logic [2:0] m);
		u_node.send(d, m);
		repeat (8) @(posedge ref_clk);
	endtask
	// status then data: judged, and also the clear sequence
	task automatic rs(input logic [7:0] es, input logic [7:0] ed, input logic [7:0] dm);
		logic [31:0] r;
		rd(10'h074, r);
		chk("status", r & 32'h2f, {24'h0, es});
		rd(10'h077, r);
		chk("data", r & {24'h0, dm}, {24'h0, ed & dm});
	endtask
	// upper byte first, then lower; the node decodes the pin
	task automatic tx(input logic [8:0] d, input logic nine);
		logic [8:0] g;
		if (nine) begin
			wr(10'h076, {1'b0, d[8], 6'h00});
		end
		wr(10'h077, d[7:0]);
		u_node.recv(g, nine);
		chk("tx word", {23'h0, g}, {23'h0, d});
	endtask
	////////////////////////////////
	task automatic t_regs();
		logic [31:0] r;
		logic e;
		rd(10'h074, r);
		chk("tx flags", r & 32'hc0, 32'hc0);
		rd(10'h070, r);
		chk("baud high", r, 32'h0);
		rd(10'h071, r);
		chk("baud low", r, 32'h4);
		rd(10'h072, r);
		chk("ctrl one", r, 32'h0);
		wr(10'h070, 8'hff);
		rd(10'h070, r);
		chk("baud high bits", r, 32'hdf);
		wr(10'h070, 8'h00);
		wr(10'h072, 8'h20);
		rd(10'h072, r);
		chk("ctrl one bits", r, 32'h0);
		apb(1'b0, 10'h075, 8'h00, r, e);
		chk("unmapped err", {31'h0, e}, 32'h1);
		wr(10'h071, 8'h01);
		wr(10'h073, 8'h0c);
	endtask
	task automatic t_basic();
		fr(9'h0a5, 3'b000);
		rs(8'h20, 8'ha5, 8'hff);
		tx(9'h0a5, 1'b0);
	endtask
	// overrun beats framing; held word survives
	task automatic t_errors();
		fr(9'h011, 3'b000);
		fr(9'h022, 3'b010);
		rs(8'h28, 8'h11, 8'hff);
		rs(8'h00, 8'h00, 8'h00);
		fr(9'h033, 3'b010);
		rs(8'h22, 8'h33, 8'hff);
		rs(8'h00, 8'h00, 8'h00);
		fr(9'h05a, 3'b001);
		rs(8'h24, 8'h5a, 8'hff);
	endtask
	// even then odd; parity takes the top data bit
	task automatic t_parity();
		logic p;
		for (int o = 0; o < 2; o++) begin
			p = (^7'h03) ^ o[0];
			wr(10'h072, {7'h01, o[0]});
			fr({1'b0, p, 7'h03}, 3'b000);
			rs(8'h20, 8'h03, 8'h7f);
			fr({1'b0, ~p, 7'h03}, 3'b000);
			rs(8'h21, 8'h03, 8'h7f);
		end
		wr(10'h072, 8'h00);
	endtask
	task automatic t_wake();
		logic [31:0] r;
		wr(10'h072, 8'h08);
		wr(10'h073, 8'h0e);
		fr(9'h012, 3'b000);
		rs(8'h00, 8'h00, 8'h00);
		fr(9'h092, 3'b000);
		rs(8'h20, 8'h92, 8'hff);
		rd(10'h073, r);
		chk("sleep after mark", r, 32'h0c);
		wr(10'h072, 8'h00);
		wr(10'h073, 8'h0e);
		fr(9'h012, 3'b000);
		repeat (200) @(posedge ref_clk);
		rd(10'h073, r);
		chk("sleep after idle", r, 32'h0c);
		rd(10'h074, r);
		rd(10'h077, r);
	endtask
	task automatic t_nine();
		logic [31:0] r;
		wr(10'h072, 8'h10);
		tx(9'h15a, 1'b1);
		fr(9'h1a5, 3'b100);
		rs(8'h20, 8'ha5, 8'hff);
		rd(10'h076, r);
		chk("ninth bit", r & 32'h80, 32'h80);
	endtask
	task automatic t_pins();
		wr(10'h072, 8'h40);
		tx(9'h00f, 1'b0);
		wr(10'h072, 8'h80);
		wr(10'h077, 8'h3c);
		repeat (200) @(posedge ref_clk);
		chk("loop pin", {31'h0, txWire}, 32'h1);
		rs(8'h20, 8'h3c, 8'hff);
		wr(10'h072, 8'h00);
	endtask
	// zero divisor: no bit timing, so no frame lands
	task automatic t_stop();
		wr(10'h071, 8'h00);
		fr(9'h055, 3'b000);
		rs(8'h00, 8'h00, 8'h00);
		wr(10'h071, 8'h01);
	endtask
	initial begin
		repeat (8) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		t_regs();
		t_basic();
		t_errors();
		t_parity();
		t_wake();
		t_nine();
		t_pins();
		t_stop();
		end_sim();
	end
endmodule
